// File: rtl/dbg_pkg.sv
// Shared constants and types of the two-wire debug port
package dbg_pkg;
  // Command byte codes
  localparam logic [7:0] CMD_MASS_ERASE = 8'h14;
  localparam logic [7:0] CMD_CFG_WR = 8'h1D;
  localparam logic [7:0] CMD_CFG_RD = 8'h24;
  localparam logic [7:0] CMD_STATUS = 8'h30;
  localparam logic [7:0] CMD_PART_ID = 8'h60;
  localparam logic [7:0] CMD_HALT = 8'h40;
  localparam logic [7:0] CMD_RESUME = 8'h48;
  localparam logic [7:0] CMD_STEP = 8'h58;
  // Injected opcode: low two bits give the opcode byte count, 0 giving one byte
  localparam logic [7:0] CMD_INJECT = 8'h50;
  localparam logic [7:0] CMD_INJECT_MASK = 8'hFC;
  // Lock byte layout and its place in the information page
  localparam int LOCK_INFO_ADDR = 0;
  localparam int BOOT_LOCK_BIT = 4;
  localparam int LOCK_SIZE_MSB = 3;
  localparam int LOCK_SIZE_LSB = 1;
  localparam int DLOCK_BIT = 0;
  localparam logic [2:0] LOCK_SIZE_ALL = 3'h0;
  localparam logic [2:0] LOCK_SIZE_NONE = 3'h7;
  localparam logic [14:0] BOOT_PAGE_LAST = 15'h03FF;
  localparam int ADDR_W = 15;
  localparam int KB_BYTES = 1024;
  // Debug configuration and status layout
  localparam int CFG_INFO_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int ST_ERASE_BIT = 7;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_DLOCK_BIT = 2;
  localparam int ST_INFO_BIT = 0;
  // Link framing
  localparam logic [1:0] ENTRY_EDGES = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] MAX_HOST_BYTES = 3'h4;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
  } dbg_cmd_t;

  // Protected size in KB at the top of flash
  function automatic logic [5:0] lock_kb(input logic [2:0] lock_size);
    case (lock_size)
      3'h0: lock_kb = 6'h20;
      3'h1: lock_kb = 6'h18;
      3'h2: lock_kb = 6'h10;
      3'h3: lock_kb = 6'h08;
      3'h4: lock_kb = 6'h04;
      3'h5: lock_kb = 6'h02;
      3'h6: lock_kb = 6'h01;
      default: lock_kb = 6'h00;
    endcase
  endfunction
endpackage

// File: rtl/two_wire_debug_port.sv
// Two-wire debug port: entry, link framing, lock and flash write guard
// Overview of operation
// - Two debug clock rising edges while chip reset is low enter debug mode.
// - In debug mode data pin is two-way, clock pin input; else GPIO.
// - Line driver changes data on rising edge; receiver samples on falling edge.
// - A command is one to four host bytes, then one returned byte.
// - All bytes travel most significant bit first.
// - Lock byte sits at information page location 0; page reachable by debug only.
// - Lock size protects 0 to 32 KB downward from the top of flash.
// - Smaller flash variants honour only lock size 0 and 7.
// - Boot page lock at 0 protects addresses 0x0000 through 0x03FF.
// - Debug lock at 0 ignores all but erase, status and identity reads.
// - Reported debug lock refreshes only on halt, resume, inject, step or reset.
// - Mass erase sets all flash bits, clearing every lock.
// - Lock bits are written through normal flash writes with info page selected.
// - Debug configuration holding info page select is written only by debug port.
// - Erase, config write and config read codes; only status reads during erase, but the port does not block other commands then.
// - Lock byte: boot lock bit 4, lock size bits 3:1, debug lock bit 0.
module two_wire_debug_port #(
  parameter int FLASH_KB = 32,
  parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary identity value
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link clock, the debug clock pin
  input wire logic dbg_clk,
  // Pins as levels
  input wire logic chip_rst_n,
  input wire logic clk_pin_lvl,
  input wire logic data_pin_i,
  output logic data_pin_o,
  output logic data_pin_oe,
  output logic gpio_release,
  output logic debug_mode,
  // Commands for the CPU debug engine
  output logic cmd_valid,
  input wire logic cmd_ready,
  output dbg_pkg::dbg_cmd_t cmd,
  // Flash controller
  input wire logic [7:0] lock_byte,
  output logic erase_req,
  input wire logic erase_done,
  input wire logic wr_req,
  input wire logic wr_info,
  input wire logic [dbg_pkg::ADDR_W-1:0] wr_addr,
  output logic wr_allow,
  output logic info_sel,
  output logic dlock_status
);
  if (FLASH_KB != 8 && FLASH_KB != 16 && FLASH_KB != 32) begin : g_chk
    $error("FLASH_KB must be 8, 16 or 32");
  end

  function automatic logic [2:0] cmd_len(input logic [7:0] op);
    if (op == dbg_pkg::CMD_CFG_WR) begin
      cmd_len = 3'h2;
    end else if ((op & dbg_pkg::CMD_INJECT_MASK) == dbg_pkg::CMD_INJECT) begin
      cmd_len = (op[1:0] == 2'h0) ? 3'h2 : 3'({1'b0, op[1:0]} + 3'h1);
    end else begin
      cmd_len = 3'h1;
    end
  endfunction

  // ---------------- Core domain: entry detection ----------------
  logic c_rst1_r, c_rst2_r, c_ck1_r, c_ck2_r, c_ck3_r;
  logic [1:0] c_edges_r;
  logic debug_mode_r, gpio_rel_r;
  wire c_rise = c_ck2_r & !c_ck3_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_rst1_r <= 1'b1;
      c_rst2_r <= 1'b1;
      c_ck1_r <= 1'b0;
      c_ck2_r <= 1'b0;
      c_ck3_r <= 1'b0;
    end else begin
      c_rst1_r <= chip_rst_n;
      c_rst2_r <= c_rst1_r;
      c_ck1_r <= clk_pin_lvl;
      c_ck2_r <= c_ck1_r;
      c_ck3_r <= c_ck2_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_edges_r <= 2'h0;
      debug_mode_r <= 1'b0;
      gpio_rel_r <= 1'b1;
    end else begin
      gpio_rel_r <= !debug_mode_r;
      if (!debug_mode_r && c_rst2_r) begin
        c_edges_r <= 2'h0;
      end else if (!debug_mode_r && c_rise) begin
        c_edges_r <= c_edges_r + 2'h1;
        if (c_edges_r + 2'h1 == dbg_pkg::ENTRY_EDGES) debug_mode_r <= 1'b1;
      end
    end
  end

  // ---------------- Link domain ----------------
  // Held in reset outside debug mode; the entry edges on the link clock land then
  wire l_rst_n = arst_n & debug_mode_r;
  logic [2:0] l_bit_r;
  logic [1:0] l_idx_r;
  logic [7:0] l_sh_r, l_resp_r, l_cfg_r;
  logic l_tx_r, l_req_r, l_out_r, l_oe_r, l_ack1_r, l_ack2_r;
  logic [7:0] l_txsh_r;
  logic [2:0] l_st1_r, l_st2_r;
  dbg_pkg::dbg_cmd_t l_word_r;
  logic c_ack_r;
  logic [2:0] c_st_r;

  wire [7:0] l_byte = {l_sh_r[6:0], data_pin_i};
  wire l_last = (l_bit_r == dbg_pkg::LAST_BIT) && !l_tx_r;
  wire [7:0] l_op = (l_idx_r == 2'h0) ? l_byte : l_word_r.op;
  wire [2:0] l_need = cmd_len(l_op);
  wire l_done = l_last && (3'({1'b0, l_idx_r}) + 3'h1 == l_need);
  wire l_free = (l_req_r == l_ack2_r);
  wire l_locked = !l_st2_r[0];
  wire l_open = (l_op == dbg_pkg::CMD_MASS_ERASE) || (l_op == dbg_pkg::CMD_STATUS)
    || (l_op == dbg_pkg::CMD_PART_ID);
  wire l_allowed = !l_locked || l_open;
  wire l_posted = (l_op == dbg_pkg::CMD_MASS_ERASE) || (l_op == dbg_pkg::CMD_HALT)
    || (l_op == dbg_pkg::CMD_RESUME) || (l_op == dbg_pkg::CMD_STEP)
    || ((l_op & dbg_pkg::CMD_INJECT_MASK) == dbg_pkg::CMD_INJECT);
  wire [7:0] l_status = (8'(l_st2_r[2]) << dbg_pkg::ST_ERASE_BIT)
    | (8'(!l_free) << dbg_pkg::ST_BUSY_BIT)
    | (8'(l_st2_r[1]) << dbg_pkg::ST_DLOCK_BIT)
    | (8'(l_cfg_r[dbg_pkg::CFG_INFO_BIT]) << dbg_pkg::ST_INFO_BIT);
  wire [7:0] l_reply = !l_allowed ? 8'h00
    : (l_op == dbg_pkg::CMD_CFG_RD) ? l_cfg_r
    : (l_op == dbg_pkg::CMD_PART_ID) ? PART_ID : l_status;

  // Falling edge: sample host bits, frame bytes and commands
  always_ff @(negedge dbg_clk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      l_bit_r <= 3'h0;
      l_idx_r <= 2'h0;
      l_sh_r <= 8'h00;
      l_tx_r <= 1'b0;
      l_resp_r <= 8'h00;
      l_cfg_r <= dbg_pkg::CFG_RESET;
      l_req_r <= 1'b0;
      l_word_r <= '0;
    end else begin
      l_bit_r <= l_bit_r + 3'h1;
      if (!l_tx_r) l_sh_r <= l_byte;
      if (l_last) begin
        case (l_idx_r)
          2'h0: l_word_r.op <= l_byte;
          2'h1: l_word_r.d0 <= l_byte;
          2'h2: l_word_r.d1 <= l_byte;
          default: l_word_r.d2 <= l_byte;
        endcase
        l_idx_r <= l_done ? 2'h0 : l_idx_r + 2'h1;
      end
      if (l_done) begin
        l_tx_r <= 1'b1;
        l_resp_r <= l_reply;
        if (l_allowed && l_posted && l_free) l_req_r <= !l_req_r;
        if (l_allowed && l_op == dbg_pkg::CMD_CFG_WR) l_cfg_r <= l_byte;
      end
      if (l_tx_r && l_bit_r == dbg_pkg::LAST_BIT) l_tx_r <= 1'b0;
    end
  end

  // Rising edge: drive the returned byte, sync core state
  always_ff @(posedge dbg_clk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      l_out_r <= 1'b0;
      l_oe_r <= 1'b0;
      l_txsh_r <= 8'h00;
      l_ack1_r <= 1'b0;
      l_ack2_r <= 1'b0;
      l_st1_r <= 3'h0;
      l_st2_r <= 3'h0;
    end else begin
      l_ack1_r <= c_ack_r;
      l_ack2_r <= l_ack1_r;
      l_st1_r <= c_st_r;
      l_st2_r <= l_st1_r;
      if (l_tx_r && !l_oe_r) begin
        l_oe_r <= 1'b1;
        l_out_r <= l_resp_r[7];
        l_txsh_r <= {l_resp_r[6:0], 1'b0};
      end else if (l_tx_r) begin
        l_out_r <= l_txsh_r[7];
        l_txsh_r <= {l_txsh_r[6:0], 1'b0};
      end else begin
        l_oe_r <= 1'b0;
        l_out_r <= 1'b0;
      end
    end
  end

  // ---------------- Core domain: command buffer ----------------
  logic c_req1_r, c_req2_r, c_cfg1_r, c_cfg2_r;
  logic c_wp_r, c_rp_r, c_busy_r, c_erq_r, c_ov_r, c_init_r;
  logic c_dlock_r, c_live_r, c_allow_r;
  logic [1:0] c_cnt_r;
  dbg_pkg::dbg_cmd_t c_mem_r [2];
  dbg_pkg::dbg_cmd_t c_out_r;

  wire c_full = (c_cnt_r == 2'h2);
  wire c_empty = (c_cnt_r == 2'h0);
  wire c_push = (c_req2_r ^ c_ack_r) && !c_full;
  wire dbg_pkg::dbg_cmd_t c_head = c_mem_r[c_rp_r];
  wire c_head_erase = (c_head.op == dbg_pkg::CMD_MASS_ERASE);
  wire c_pop_erase = !c_empty && c_head_erase && !c_busy_r;
  wire c_pop_cpu = !c_empty && !c_head_erase && (!c_ov_r || cmd_ready);
  wire c_pop = c_pop_erase || c_pop_cpu;

  always_ff @(posedge clk) begin
    if (c_push) c_mem_r[c_wp_r] <= l_word_r;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_req1_r <= 1'b0;
      c_req2_r <= 1'b0;
      c_cfg1_r <= 1'b0;
      c_cfg2_r <= 1'b0;
      c_ack_r <= 1'b0;
      c_wp_r <= 1'b0;
      c_rp_r <= 1'b0;
      c_cnt_r <= 2'h0;
    end else begin
      c_req1_r <= l_req_r;
      c_req2_r <= c_req1_r;
      c_cfg1_r <= l_cfg_r[dbg_pkg::CFG_INFO_BIT];
      c_cfg2_r <= c_cfg1_r;
      if (c_push) begin
        c_ack_r <= !c_ack_r;
        c_wp_r <= !c_wp_r;
      end
      if (c_pop) c_rp_r <= !c_rp_r;
      c_cnt_r <= c_cnt_r + 2'(c_push) - 2'(c_pop);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_ov_r <= 1'b0;
      c_out_r <= '0;
      c_busy_r <= 1'b0;
      c_erq_r <= 1'b0;
    end else begin
      if (c_pop_cpu) begin
        c_ov_r <= 1'b1;
        c_out_r <= c_head;
      end else if (cmd_ready) begin
        c_ov_r <= 1'b0;
      end
      c_erq_r <= c_pop_erase;
      if (c_pop_erase) c_busy_r <= 1'b1;
      else if (erase_done) c_busy_r <= 1'b0;
    end
  end

  // Lock state and flash write guard
  wire [2:0] c_lock_size = lock_byte[dbg_pkg::LOCK_SIZE_MSB:dbg_pkg::LOCK_SIZE_LSB];
  wire [2:0] c_lsz_eff = (FLASH_KB == 32 || c_lock_size == dbg_pkg::LOCK_SIZE_ALL) ? c_lock_size
    : dbg_pkg::LOCK_SIZE_NONE;
  wire [15:0] c_kb = 16'(dbg_pkg::lock_kb(c_lsz_eff));
  wire [15:0] c_base = 16'(FLASH_KB * dbg_pkg::KB_BYTES) - 16'(c_kb * 16'(dbg_pkg::KB_BYTES));
  wire c_top_prot = (c_kb != 16'h0)
    && (c_kb >= 16'(FLASH_KB) || {1'b0, wr_addr} >= c_base);
  wire c_boot_prot = !lock_byte[dbg_pkg::BOOT_LOCK_BIT]
    && (wr_addr <= dbg_pkg::BOOT_PAGE_LAST);
  wire c_allow = wr_info ? c_cfg2_r : !(c_top_prot || c_boot_prot);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_init_r <= 1'b1;
      c_dlock_r <= 1'b0;
      c_live_r <= 1'b0;
      c_allow_r <= 1'b0;
      c_st_r <= 3'h0;
    end else begin
      c_init_r <= 1'b0;
      c_live_r <= lock_byte[dbg_pkg::DLOCK_BIT];
      if (c_init_r || c_pop_cpu) c_dlock_r <= lock_byte[dbg_pkg::DLOCK_BIT];
      c_allow_r <= wr_req && c_allow;
      c_st_r <= {c_busy_r, c_dlock_r, c_live_r};
    end
  end

  assign data_pin_o = l_out_r;
  assign data_pin_oe = l_oe_r;
  assign gpio_release = gpio_rel_r;
  assign debug_mode = debug_mode_r;
  assign cmd_valid = c_ov_r;
  assign cmd = c_out_r;
  assign erase_req = c_erq_r;
  assign wr_allow = c_allow_r;
  assign info_sel = c_cfg2_r;
  assign dlock_status = c_dlock_r;

  // ---------------- Checks ----------------
  sequence s_second_edge;
    !debug_mode_r && !c_rst2_r && c_rise && c_edges_r == 2'h1;
  endsequence
  entry_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_second_edge |=> debug_mode_r ##1 !gpio_rel_r) else $error("debug entry missed");
  gpio_hand_a: assert property (@(posedge clk) disable iff (!arst_n)
    !debug_mode_r |=> gpio_rel_r) else $error("pins left by GPIO outside debug");
  sequence s_reply_msb;
    $rose(l_oe_r) && l_out_r == l_resp_r[7];
  endsequence
  reply_msb_a: assert property (@(posedge dbg_clk) disable iff (!l_rst_n)
    $rose(l_oe_r) |-> s_reply_msb ##7 l_out_r == l_resp_r[0]) else $error("reply order");
  drive_window_a: assert property (@(posedge dbg_clk) disable iff (!l_rst_n)
    $rose(l_oe_r) |-> l_oe_r[*8] ##1 !l_oe_r) else $error("drive window not 8 bits");
  fall_sample_a: assert property (@(negedge dbg_clk) disable iff (!l_rst_n)
    !l_tx_r |=> l_sh_r[0] == $past(data_pin_i)) else $error("falling edge sample lost");
  fourth_ends_a: assert property (@(negedge dbg_clk) disable iff (!l_rst_n)
    l_last && l_idx_r == 2'h3 |-> l_done) else $error("command beyond four bytes");
  lock_ignore_a: assert property (@(negedge dbg_clk) disable iff (!l_rst_n)
    l_done && !l_allowed |=> $stable(l_req_r) && $stable(l_cfg_r) && l_resp_r == 8'h00)
    else $error("locked command acted");
  lock_refresh_a: assert property (@(posedge clk) disable iff (!arst_n)
    !c_init_r && !c_pop_cpu |=> $stable(c_dlock_r)) else $error("lock status moved");
  boot_guard_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_req && !wr_info && wr_addr <= dbg_pkg::BOOT_PAGE_LAST
    && !lock_byte[dbg_pkg::BOOT_LOCK_BIT] |=> !c_allow_r) else $error("boot page written");
  full_guard_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_req && !wr_info && c_lock_size == dbg_pkg::LOCK_SIZE_ALL |=> !c_allow_r)
    else $error("locked flash written");
  info_guard_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_req && wr_info && !c_cfg2_r |=> !c_allow_r) else $error("info page unselected");
  erase_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    c_pop_erase |=> c_erq_r && c_busy_r ##1 !c_erq_r) else $error("erase request shape");
endmodule

// File: verif/dbg_host_model.sv
// Debug host model that drives the two-wire link
module dbg_host_model (
  // Link pins
  output logic dbg_clk,
  output logic data_pin_i,
  input wire logic data_pin_o,
  input wire logic data_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  logic val;
  logic last;
  // Released line shows the inverse of the last driven bit
  assign data_pin_i = data_pin_oe ? data_pin_o : (drv ? val : ~last);
  initial begin
    dbg_clk = 1'b0;
    drv = 1'b0;
    val = 1'b0;
    last = 1'b0;
  end
  // Clock pin pulsed twice while chip reset is held low
  // Short high phase: each fall lands before the link leaves reset
  task automatic entry_edges();
    #3;
    repeat (2) begin
      dbg_clk = 1'b1;
      #15;
      dbg_clk = 1'b0;
      #65;
    end
  endtask
  // Host is only used at full clock speed and never in deep sleep
  task automatic xfer(input int n, input logic [31:0] b, output logic [7:0] r);
    for (int i = 0; i < 8 * n; i++) begin
      dbg_clk = 1'b1;
      drv = 1'b1;
      val = b[31-i];
      last = b[31-i];
      #40;
      dbg_clk = 1'b0;
      #40;
    end
    drv = 1'b0;
    for (int i = 0; i < 8; i++) begin
      dbg_clk = 1'b1;
      #40;
      dbg_clk = 1'b0;
      r[7-i] = data_pin_i;
      #40;
    end
  endtask
endmodule

// File: verif/tb_top.sv
// Testbench for the two-wire debug port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'hA5; // Arbitrary identity value
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic chip_rst_n = 1'b1;
  logic cmd_ready = 1'b0;
  logic erase_done = 1'b0;
  logic wr_req = 1'b0;
  logic wr_info = 1'b0;
  logic [7:0] lock_byte = 8'hFF;
  logic [dbg_pkg::ADDR_W-1:0] wr_addr = 15'h0000;
  logic dbg_clk, data_pin_i, data_pin_o, data_pin_oe, gpio_release, debug_mode;
  logic cmd_valid, erase_req, wr_allow, info_sel, dlock_status;
  dbg_pkg::dbg_cmd_t cmd;
  logic [7:0] r;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_erase = 0;
  int kb_tab [8] = '{32, 24, 16, 8, 4, 2, 1, 0};
  always #5 clk = ~clk;
  // One-clock erase pulse lands inside the reply, so count it here
  always @(posedge clk) begin
    if (erase_req === 1'b1) n_erase <= n_erase + 1;
  end

  two_wire_debug_port #(.FLASH_KB(32), .PART_ID(ID)) i_two_wire_debug_port (
    .clk(clk), .arst_n(arst_n), .dbg_clk(dbg_clk), .chip_rst_n(chip_rst_n),
    .clk_pin_lvl(dbg_clk), .data_pin_i(data_pin_i), .data_pin_o(data_pin_o),
    .data_pin_oe(data_pin_oe), .gpio_release(gpio_release), .debug_mode(debug_mode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .lock_byte(lock_byte),
    .erase_req(erase_req), .erase_done(erase_done), .wr_req(wr_req), .wr_info(wr_info),
    .wr_addr(wr_addr), .wr_allow(wr_allow), .info_sel(info_sel), .dlock_status(dlock_status));
  dbg_host_model i_dbg_host_model (.dbg_clk(dbg_clk), .data_pin_i(data_pin_i),
    .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe));

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = debug_mode;
      1: pick = cmd_valid;
      2: pick = (n_erase != 0);
      default: pick = info_sel;
    endcase
  endfunction
  task automatic wait_sig(input int w, input int lim);
    int k;
    k = 0;
    while (pick(w) !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= lim) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic cmd_io(input int n, input logic [31:0] c, input logic [7:0] exp);
    i_dbg_host_model.xfer(n, c, r);
    check(r, exp);
  endtask
  // One write request, then compare the guard answer
  task automatic fw(input logic info, input int a, input logic [7:0] lb, input logic isel);
    logic e;
    int kb;
    kb = kb_tab[lb[3:1]];
    a = a & 32'h7FFF;
    e = info ? isel : !((a <= 32'h3FF && !lb[4]) || a >= 32768 - kb * 1024);
    @(posedge clk);
    lock_byte <= lb;
    wr_req <= 1'b1;
    wr_info <= info;
    wr_addr <= a[14:0];
    @(posedge clk);
    wr_req <= 1'b0;
    #1;
    check(wr_allow, e);
  endtask
  // Posted command must reach the engine output and hold until taken
  task automatic post(input int n, input logic [31:0] c, input logic dl);
    logic [31:0] m;
    m = 32'hFFFFFFFF << (8 * (4 - n));
    i_dbg_host_model.xfer(n, c, r);
    wait_sig(1, 60);
    repeat (20) @(posedge clk);
    #1;
    check(cmd_valid, 1'b1);
    check(cmd & m, c & m);
    check(dlock_status, dl);
    @(posedge clk);
    cmd_ready <= 1'b1;
    @(posedge clk);
    cmd_ready <= 1'b0;
    #1;
    check(cmd_valid, 1'b0);
  endtask
  task automatic enter();
    @(posedge clk);
    chip_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    i_dbg_host_model.entry_edges();
    wait_sig(0, 40);
    repeat (2) @(posedge clk);
    chip_rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check(gpio_release, 1'b0);
  endtask

  initial begin
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check({data_pin_oe, gpio_release, debug_mode}, 3'b010);
    enter();
    cmd_io(1, {dbg_pkg::CMD_STATUS, 24'h0}, 8'h04);
    i_dbg_host_model.xfer(2, {dbg_pkg::CMD_CFG_WR, 8'h01, 16'h0}, r);
    cmd_io(1, {dbg_pkg::CMD_CFG_RD, 24'h0}, 8'h01);
    wait_sig(3, 20);
    for (int s = 0; s < 8; s++) begin
      fw(0, 32767 - kb_tab[s] * 1024, {4'h1, s[2:0], 1'b1}, 1'b1);
      fw(0, 32768 - kb_tab[s] * 1024, {4'h1, s[2:0], 1'b1}, 1'b1);
    end
    fw(0, 32'h3FF, 8'hEF, 1'b1);
    fw(0, 32'h400, 8'hEF, 1'b1);
    fw(0, 32'h3FF, 8'hFF, 1'b1);
    fw(1, 0, 8'hFF, 1'b1);
    post(1, {dbg_pkg::CMD_HALT, 24'h0}, 1'b1);
    post(4, {dbg_pkg::CMD_INJECT | 8'h03, 24'h123456}, 1'b1);
    @(posedge clk);
    lock_byte <= 8'hFE;
    cmd_io(1, {dbg_pkg::CMD_HALT, 24'h0}, 8'h00);
    repeat (30) @(posedge clk);
    #1;
    check(cmd_valid, 1'b0);
    cmd_io(1, {dbg_pkg::CMD_PART_ID, 24'h0}, ID);
    cmd_io(1, {dbg_pkg::CMD_STATUS, 24'h0}, 8'h05);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({debug_mode, dlock_status}, 2'b00);
    enter();
    cmd_io(1, {dbg_pkg::CMD_STATUS, 24'h0}, 8'h00);
    fw(1, 0, 8'hFE, 1'b0);
    i_dbg_host_model.xfer(1, {dbg_pkg::CMD_MASS_ERASE, 24'h0}, r);
    wait_sig(2, 60);
    check(n_erase, 1);
    repeat (4) @(posedge clk);
    i_dbg_host_model.xfer(1, {dbg_pkg::CMD_STATUS, 24'h0}, r);
    check(r & 8'h80, 8'h80);
    @(posedge clk);
    erase_done <= 1'b1;
    lock_byte <= 8'hFF;
    @(posedge clk);
    erase_done <= 1'b0;
    repeat (10) @(posedge clk);
    post(2, {dbg_pkg::CMD_INJECT | 8'h01, 24'h0}, 1'b1);
    cmd_io(1, {dbg_pkg::CMD_STATUS, 24'h0}, 8'h04);
    report_and_stop();
  end
endmodule
